/* File: include/sscl_pkg.sv */
// package of constants and carrier types for the simultaneous sample channel list sequencer
package sscl_pkg;
   // register offsets (word index == byte address / 4 not used; plain port addresses)
   localparam logic [3:0] SSCL_REG_CTRL = 4'h0;
   localparam logic [3:0] SSCL_REG_DIV = 4'h1;
   localparam logic [3:0] SSCL_REG_LEN = 4'h2;
   localparam logic [3:0] SSCL_REG_LIST = 4'h3;
   localparam logic [3:0] SSCL_REG_STAT = 4'h4;
   localparam logic [3:0] SSCL_REG_CLR = 4'h5;
   localparam logic [3:0] SSCL_REG_IEN = 4'h6;
   localparam logic [3:0] SSCL_REG_GAIN = 4'h7;
   // control field positions
   localparam int SSCL_CTRL_RUN = 0;
   localparam int SSCL_CTRL_EXT = 1;
   // status field positions
   localparam int SSCL_ST_OVERSAMPLE = 0;
   localparam int SSCL_ST_OVERFLOW = 1;
   localparam int SSCL_ST_RECORD = 2;
   localparam int SSCL_ST_W = 3;
   // reset values
   localparam logic [31:0] SSCL_DIV_RST = 32'h0000_0010;
   localparam logic [3:0] SSCL_LEN_RST = 4'h1;
   localparam logic [15:0] SSCL_GAIN_ONE = 16'h0001;
   // clock and rate figures
   localparam int SSCL_CLK_HZ = 20_000_000;
   localparam int SSCL_MAX_RATE4_HZ = 1_250_000;
   localparam int SSCL_MAX_RATE2_HZ = 2_000_000;
   // least divider for the fastest documented internal rate
   localparam int SSCL_MIN_DIV4 = SSCL_CLK_HZ / SSCL_MAX_RATE4_HZ;
   localparam int SSCL_MIN_DIV2 = SSCL_CLK_HZ / SSCL_MAX_RATE2_HZ;
   // slowest rate 0.01118 Hz needs a divider of about 1.79e9, fits 32 bits
   localparam logic [31:0] SSCL_MAX_DIV = 32'h6aa9_5fc0;
   // offset binary full scale codes
   localparam logic [15:0] SSCL_NEG_FS = 16'h0000;
   localparam logic [15:0] SSCL_POS_FS = 16'hffff;

   // one output word of a record
   typedef struct packed {
      logic [15:0] data;
      logic [3:0] entry;
      logic last;
   } sscl_word_t;

   // converter request
   typedef struct packed {
      logic start;
   } sscl_conv_req_t;

   typedef enum logic [1:0] {
      SSCL_IDLE,
      SSCL_WAIT,
      SSCL_EMIT,
      SSCL_HALT
   } sscl_state_t;
endpackage

/* File: hdl/sscl_sequencer.sv */
// simultaneous sample channel list sequencer
//
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/1ps
module sscl_sequencer import sscl_pkg::*; #(
   parameter int NUM_AI = 4,
   parameter int AI_W = 18
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic irq,
   // external sample clock, synchronous input
   input wire logic ext_sample_clk,
   // converters: signed two's complement result, at least 16 bits wide
   output logic conv_start,
   input wire logic conv_busy,
   input wire logic conv_done,
   input wire logic [NUM_AI*AI_W-1:0] conv_result,
   // digital port, counters, decoders
   input wire logic [15:0] din_port,
   input wire logic [31:0] counter0_value,
   input wire logic [31:0] counter1_value,
   input wire logic [95:0] decoder_value,
   // record output stream toward the holding queue
   output sscl_word_t rec_word,
   output logic rec_valid,
   input wire logic queue_full
);
   localparam int DIN_CH = NUM_AI;
   localparam int CNT_BASE = NUM_AI + 1;
   localparam int DEC_BASE = NUM_AI + 5;
   localparam int MAX_LEN = NUM_AI + 11;
   localparam logic [31:0] MIN_DIV = 32'((NUM_AI == 4) ? SSCL_MIN_DIV4 : SSCL_MIN_DIV2);

   initial begin
      if (NUM_AI != 4 && NUM_AI != 2) begin
         $error("NUM_AI must be 2 or 4");
      end
      if (AI_W < 16) begin
         $error("AI_W must be at least 16");
      end
      if (AI_W > 32) begin
         $error("AI_W must be at most 32");
      end
      if (DEC_BASE + 6 != MAX_LEN) begin
         $error("decoder entries must end the map");
      end
      if (MAX_LEN > 15) begin
         $error("list longer than fifteen slots");
      end
   end

   // configuration registers
   logic run_q;
   logic ext_sel_q;
   logic [31:0] div_q;
   logic [3:0] len_q;
   logic [3:0] list_q [0:14];
   logic [SSCL_ST_W-1:0] stat_q;
   logic [SSCL_ST_W-1:0] ien_q;

   // capture state
   sscl_state_t state_q;
   logic [15:0] snap_q [0:14];
   logic [3:0] idx_q;
   logic [31:0] tick_cnt_q;
   logic ext_prev_q;
   logic sample_tick;
   logic ev_oversample;
   logic ev_overflow;
   logic ev_record;

   // next values and shared strobes
   logic [31:0] div_d;
   logic [3:0] len_d;
   logic [31:0] rdata_d;
   logic [3:0] last_idx;
   logic [SSCL_ST_W-1:0] ev_vec;
   logic [SSCL_ST_W-1:0] clr_vec;
   logic int_tick;
   logic ext_fall;
   logic snap_take;
   logic entry_known;
   logic list_wr;

   // divider clamp so the internal rate stays in range
   always_comb begin
      if (reg_wdata < MIN_DIV) begin
         div_d = MIN_DIV;
      end else if (reg_wdata > SSCL_MAX_DIV) begin
         div_d = SSCL_MAX_DIV;
      end else begin
         div_d = reg_wdata;
      end
   end

   // length clamp; zero would leave a record with no last word
   always_comb begin
      if (reg_wdata[3:0] == 4'h0) begin
         len_d = 4'h1;
      end else if (32'(reg_wdata[3:0]) > MAX_LEN) begin
         len_d = 4'(MAX_LEN);
      end else begin
         len_d = reg_wdata[3:0];
      end
   end

   // run and source select; an error stops acquisition until software restarts it
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         run_q <= 1'b0;
         ext_sel_q <= 1'b0;
      end else begin
         if (reg_wr && reg_addr == SSCL_REG_CTRL) begin
            run_q <= reg_wdata[SSCL_CTRL_RUN];
            ext_sel_q <= reg_wdata[SSCL_CTRL_EXT];
         end
         if (ev_oversample || ev_overflow) begin
            run_q <= 1'b0;
         end
      end
   end

   // remaining host writes
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         div_q <= SSCL_DIV_RST;
         len_q <= SSCL_LEN_RST;
         ien_q <= '0;
      end else if (reg_wr) begin
         case (reg_addr)
            SSCL_REG_DIV: begin
               div_q <= div_d;
            end
            SSCL_REG_LEN: begin
               len_q <= len_d;
            end
            SSCL_REG_IEN: begin
               ien_q <= reg_wdata[SSCL_ST_W-1:0];
            end
            default: begin
            end
         endcase
      end
   end

   // slot 15 does not exist, so its writes are dropped
   assign list_wr = reg_wr && reg_addr == SSCL_REG_LIST && reg_wdata[7:4] < 4'hf;

   // list write: word bits [7:4] pick slot, [3:0] the entry number
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         for (int i = 0; i < 15; i++) begin
            list_q[i] <= 4'h0;
         end
      end else if (list_wr) begin
         list_q[reg_wdata[7:4]] <= reg_wdata[3:0];
      end
   end

   // internal divider makes a one-cycle enable; external takes falling edges
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         tick_cnt_q <= '0;
         ext_prev_q <= 1'b0;
      end else begin
         ext_prev_q <= ext_sample_clk;
         if (!run_q || ext_sel_q || tick_cnt_q >= div_q - 32'h1) begin
            tick_cnt_q <= '0;
         end else begin
            tick_cnt_q <= tick_cnt_q + 32'h1;
         end
      end
   end

   // one pulse per sample, either source, no rate change for external
   assign int_tick = (tick_cnt_q >= div_q - 32'h1);
   assign ext_fall = ext_prev_q && !ext_sample_clk;
   // reset value of the edge flop matches the idle low pin, so no false edge
   assign sample_tick = run_q && (ext_sel_q ? ext_fall : int_tick);

   // saturate a signed result to offset binary 16 bits
   function automatic logic [15:0] to_offset_bin(input logic [AI_W-1:0] v);
      logic signed [AI_W-1:0] s;
      s = $signed(v);
      if (s > $signed(AI_W'(32767))) begin
         to_offset_bin = SSCL_POS_FS;
      end else if (s < -$signed(AI_W'(32768))) begin
         to_offset_bin = SSCL_NEG_FS;
      end else begin
         to_offset_bin = {~v[15], v[14:0]};
      end
   endfunction

   // tick while converting or emitting is an over-sample
   assign ev_oversample = sample_tick && (state_q != SSCL_IDLE || conv_busy);
   assign ev_overflow = rec_valid && queue_full;
   assign ev_record = rec_valid && rec_word.last && !queue_full;

   // sequencer: snapshot all sources on the tick, then emit in list order
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_q <= SSCL_IDLE;
         idx_q <= 4'h0;
         for (int i = 0; i < 15; i++) begin
            snap_q[i] <= 16'h0000;
         end
      end else begin
         case (state_q)
            SSCL_IDLE: begin
               if (snap_take) begin
                  // digital, counters and decoders latched on the same tick
                  snap_q[DIN_CH] <= din_port;
                  snap_q[CNT_BASE] <= counter0_value[15:0];
                  snap_q[CNT_BASE+1] <= counter0_value[31:16];
                  snap_q[CNT_BASE+2] <= counter1_value[15:0];
                  snap_q[CNT_BASE+3] <= counter1_value[31:16];
                  for (int d = 0; d < 6; d++) begin
                     snap_q[DEC_BASE+d] <= decoder_value[16*d +: 16];
                  end
                  state_q <= SSCL_WAIT;
               end
            end
            SSCL_WAIT: begin
               // all analog results arrive together on one done pulse
               if (conv_done) begin
                  for (int a = 0; a < NUM_AI; a++) begin
                     snap_q[a] <= to_offset_bin(conv_result[a*AI_W +: AI_W]);
                  end
                  idx_q <= 4'h0;
                  state_q <= SSCL_EMIT;
               end
            end
            SSCL_EMIT: begin
               // a full queue loses the standing word, so stop at once
               if (queue_full) begin
                  state_q <= SSCL_HALT;
               end else if (idx_q == last_idx) begin
                  state_q <= SSCL_IDLE;
               end else begin
                  idx_q <= idx_q + 4'h1;
               end
            end
            SSCL_HALT: begin
               // only a fresh run bit from software leaves the error state
               if (run_q) begin
                  state_q <= SSCL_IDLE;
               end
            end
            default: begin
               state_q <= SSCL_IDLE;
            end
         endcase
         if (ev_oversample) begin
            state_q <= SSCL_HALT;
         end
      end
   end

   // one strobe both starts the converters and freezes the other sources
   assign snap_take = (state_q == SSCL_IDLE) && sample_tick && !conv_busy;
   // converters start together, one strobe for all channels
   assign conv_start = snap_take;

   // list position of the final word of a record
   assign last_idx = len_q - 4'h1;
   // entries past the map have no source and read zero
   assign entry_known = (32'(list_q[idx_q]) < MAX_LEN);

   // record word
   always_comb begin
      rec_valid = (state_q == SSCL_EMIT);
      rec_word.entry = list_q[idx_q];
      rec_word.last = (idx_q == last_idx);
      rec_word.data = entry_known ? snap_q[list_q[idx_q]] : 16'h0000;
   end

   // event and clear vectors in status bit order
   assign ev_vec = {ev_record, ev_overflow, ev_oversample};
   assign clr_vec = (reg_wr && reg_addr == SSCL_REG_CLR) ? reg_wdata[SSCL_ST_W-1:0] : '0;

   // one sticky bit per event, set wins over clear
   for (genvar b = 0; b < SSCL_ST_W; b++) begin : g_sticky
      always_ff @(posedge ref_clk) begin
         if (rst) begin
            stat_q[b] <= 1'b0;
         end else if (ev_vec[b]) begin
            stat_q[b] <= 1'b1;
         end else if (clr_vec[b]) begin
            stat_q[b] <= 1'b0;
         end
      end
   end

   assign irq = |(stat_q & ien_q);

   // read mux; write-only and unmapped offsets read zero
   always_comb begin
      rdata_d = 32'h0;
      case (reg_addr)
         SSCL_REG_CTRL: rdata_d = {30'h0, ext_sel_q, run_q};
         SSCL_REG_DIV: rdata_d = div_q;
         SSCL_REG_LEN: rdata_d = {28'h0, len_q};
         SSCL_REG_STAT: rdata_d = {29'h0, stat_q};
         SSCL_REG_IEN: rdata_d = {29'h0, ien_q};
         SSCL_REG_GAIN: rdata_d = {16'h0, SSCL_GAIN_ONE};
         default: rdata_d = 32'h0;
      endcase
   end

   // read data one cycle after the strobe, zero otherwise
   always_ff @(posedge ref_clk) begin
      if (rst || !reg_rd) begin
         reg_rdata <= '0;
      end else begin
         reg_rdata <= rdata_d;
      end
   end
endmodule

/* File: testbench/sscl_props.sv */
// port timing checker for the channel list sequencer
`timescale 1ns/1ps
module sscl_props import sscl_pkg::*; (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // watched ports
   input wire logic [3:0] reg_addr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic conv_start,
   input wire logic conv_busy,
   input wire logic conv_done,
   input sscl_word_t rec_word,
   input wire logic rec_valid,
   input wire logic queue_full
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // record steps
   sequence s_last; rec_valid && rec_word.last; endsequence
   sequence s_full; rec_valid && queue_full; endsequence
   a_start_when_idle: assert property (conv_start |-> !conv_busy && !rec_valid) else $error("start while busy");
   a_start_one_cycle: assert property (conv_start |=> !conv_start) else $error("start too long");
   a_record_after_done: assert property ($rose(rec_valid) |-> $past(conv_done)) else $error("early record");
   a_last_word_ends: assert property (s_last |=> !rec_valid) else $error("record runs on");
   a_full_halts: assert property (s_full |=> (!rec_valid && !conv_start) [*8]) else $error("no halt");
   a_entry_in_range: assert property (rec_valid |-> rec_word.entry <= 4'he) else $error("bad entry");
   a_gain_fixed: assert property ($past(reg_rd) && $past(reg_addr) == SSCL_REG_GAIN |-> reg_rdata == 32'h1)
      else $error("gain not one");
   a_read_quiet: assert property (!$past(reg_rd) || $past(reg_addr) > 4'h7 |-> reg_rdata == 32'h0)
      else $error("read data not zero");
endmodule
bind sscl_sequencer sscl_props sscl_props_i (.ref_clk, .rst, .reg_addr, .reg_rd, .reg_rdata, .conv_start,
   .conv_busy, .conv_done, .rec_word, .rec_valid, .queue_full);

/* File: testbench/sscl_conv_model.sv */
// converter model, all channels on one timer
`timescale 1ns/1ps
module sscl_conv_model (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // request and bench controls
   input wire logic conv_start,
   input wire logic slow,
   input wire logic [71:0] res_in,
   // answer
   output logic conv_busy,
   output logic conv_done,
   output logic [71:0] conv_result
);
   int cnt;
   // one shared timer: every channel sampled at one instant
   always_ff @(posedge ref_clk) begin
      conv_done <= 1'b0;
      if (rst) begin
         cnt <= 0;
         conv_busy <= 1'b0;
      end else if (conv_start && !conv_busy) begin
         cnt <= slow ? 40 : 4;
         conv_busy <= 1'b1;
      end else if (cnt == 1) begin
         cnt <= 0;
         conv_busy <= 1'b0;
         conv_done <= 1'b1;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
      end
   end
   // result not held outside done, so stale reads show
   assign conv_result = conv_done ? res_in : ~res_in;
endmodule

/* File: testbench/sscl_sequencer_tb_top.sv */
// testbench for the channel list sequencer
`timescale 1ns/1ps
module sscl_sequencer_tb_top import sscl_pkg::*; ;
   logic ref_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, ext_sample_clk = 0, queue_full = 0, slow = 0;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0, counter0_value = 32'h0, counter1_value = 32'h0, reg_rdata;
   logic [15:0] din_port = 16'h0;
   logic [95:0] decoder_value = 96'h0;
   logic [71:0] res_in = 72'h0, conv_result;
   logic irq, conv_start, conv_busy, conv_done, rec_valid;
   sscl_word_t rec_word;
   sscl_word_t expq[$];
   logic [3:0] lst[15];
   int n_errors = 0, tests_run = 0, n_starts = 0, len = 1;
   initial forever #25 ref_clk = ~ref_clk;
   sscl_sequencer sscl_sequencer_i (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
      .ext_sample_clk, .conv_start, .conv_busy, .conv_done, .conv_result, .din_port, .counter0_value,
      .counter1_value, .decoder_value, .rec_word, .rec_valid, .queue_full);
   sscl_conv_model sscl_conv_model_i (.ref_clk, .rst, .conv_start, .slow, .res_in, .conv_busy, .conv_done,
      .conv_result);
   task automatic chk(string what, logic [31:0] e, logic [31:0] got);
      tests_run++;
      if (got !== e) begin
         n_errors++;
         $display("BAD %s exp %h got %h", what, e, got);
      end
   endtask
   // empty queue forces a mismatch
   task automatic chk_word(sscl_word_t got);
      sscl_word_t e;
      e = expq.size() ? expq.pop_front() : ~got;
      tests_run++;
      if (got !== e) begin
         n_errors++;
         $display("BAD word exp %h got %h", e, got);
      end
   endtask
   task automatic wr(logic [3:0] a, logic [31:0] d);
      @(posedge ref_clk);
      reg_wr <= 1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 0;
      #1;
   endtask
   task automatic rd(logic [3:0] a, logic [31:0] e);
      @(posedge ref_clk);
      reg_rd <= 1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 0;
      #1;
      chk("reg", e, reg_rdata);
   endtask
   // expected word for an entry: analog inputs are driven to saturation
   function automatic logic [15:0] val(logic [3:0] e);
      logic [63:0] c;
      c = {counter1_value, counter0_value};
      if (e < 4) return res_in[e*18+17] ? 16'h0000 : 16'hffff;
      if (e == 4) return din_port;
      if (e < 9) return c[(e-5)*16+:16];
      return decoder_value[(e-9)*16+:16];
   endfunction
   task automatic expect_rec(int n);
      sscl_word_t w;
      repeat (n) for (int i = 0; i < len; i++) begin
         w.data = val(lst[i]);
         w.entry = lst[i];
         w.last = (i == len - 1);
         expq.push_back(w);
      end
   endtask
   task automatic setup(int n, int div);
      din_port <= $urandom;
      counter0_value <= $urandom;
      counter1_value <= $urandom;
      decoder_value <= {$urandom, $urandom, $urandom};
      for (int c = 0; c < 4; c++) res_in[c*18+:18] <= $urandom_range(1) ? 18'h1ffff : 18'h20000;
      len = n;
      wr(SSCL_REG_CTRL, 0);
      wr(SSCL_REG_DIV, div);
      wr(SSCL_REG_LEN, n);
      for (int i = 0; i < n; i++) wr(SSCL_REG_LIST, {i[3:0], lst[i]});
   endtask
   task automatic drain;
      int t;
      t = 0;
      while (expq.size() > 0 && t < 2000) begin
         @(posedge ref_clk);
         t++;
      end
      chk("left", 0, expq.size());
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // watcher of the record stream
   always @(posedge ref_clk) begin
      if (conv_start === 1'b1) n_starts++;
      if (rec_valid === 1'b1) chk_word(rec_word);
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_errors++;
      tally_and_finish;
   end
   initial begin
      void'($urandom(59561));
      repeat (3) @(posedge ref_clk);
      rst <= 0;
      // full shuffled list, internal pacing
      lst = '{4'h7, 4'h8, 4'h3, 4'he, 4'hd, 4'h0, 4'h4, 4'h5, 4'h6, 4'h9, 4'ha, 4'h1, 4'hb, 4'hc, 4'h2};
      setup(15, 64);
      expect_rec(2);
      wr(SSCL_REG_CTRL, 1);
      drain;
      wr(SSCL_REG_CTRL, 0);
      rd(SSCL_REG_LEN, 15);
      wr(SSCL_REG_DIV, 1);
      rd(SSCL_REG_DIV, 16);
      rd(SSCL_REG_GAIN, 1);
      rd(4'h9, 0);
      $display("test list done");
      // external clock, three falling edges, even duty
      lst[0] = 4'h4;
      lst[1] = 4'h0;
      lst[2] = 4'ha;
      setup(3, 64);
      expect_rec(3);
      n_starts = 0;
      wr(SSCL_REG_CTRL, 3);
      repeat (3) begin
         repeat (40) @(posedge ref_clk);
         ext_sample_clk <= 1;
         repeat (40) @(posedge ref_clk);
         ext_sample_clk <= 0;
      end
      drain;
      chk("starts", 3, n_starts);
      $display("test external done");
      // slow converter against fast ticks
      wr(SSCL_REG_CLR, 7);
      wr(SSCL_REG_IEN, 1);
      slow <= 1;
      lst[0] = 4'h0;
      setup(1, 16);
      wr(SSCL_REG_CTRL, 1);
      repeat (120) @(posedge ref_clk);
      rd(SSCL_REG_STAT, 1);
      chk("irq", 1, irq);
      wr(SSCL_REG_IEN, 0);
      chk("irq", 0, irq);
      wr(SSCL_REG_CLR, 1);
      wr(SSCL_REG_IEN, 3);
      chk("irq", 0, irq);
      $display("test oversample done");
      // full queue: one word gets out, then halt
      slow <= 0;
      queue_full <= 1;
      lst[0] = 4'h5;
      lst[1] = 4'h6;
      setup(2, 64);
      expect_rec(1);
      void'(expq.pop_back());
      wr(SSCL_REG_CTRL, 1);
      repeat (120) @(posedge ref_clk);
      drain;
      rd(SSCL_REG_STAT, 2);
      chk("irq", 1, irq);
      queue_full <= 0;
      $display("test overflow done");
      tally_and_finish;
   end
endmodule
